/* File: hdl/sbes_top.sv */
/*
   Second status register of an asynchronous serial interface with its
   break detector, receive edge detector and receive polarity control.
   Assumes a receiver on the same clock that takes rx_data_q and reports
   its raw framing error and receive full events here for gating.
*/
// Register access over Avalon-MM and the register offsets were chosen for this implementation.
// Functional notes
// - Break flag, bit 7, sets when break detection is enabled and break seen.
// - Writing one to the break flag clears it.
// - Edge flag, bit 6, sets on falling edge, or rising when inverted.
// - Writing one to the edge flag clears it.
// - Bit 4 inverts incoming serial data before the receiver sees it.
// - Inversion covers data, start, stop, break and idle levels alike.
// - Break enable lengthens break to 11 or 12 bits, suppresses error and full.
`timescale 1ns/1ns
module sbes_top
   import sbes_pkg::*;
#(
   parameter int DW = DIV_W,
   parameter logic [DW-1:0] DIV_INIT = DIV_RESET
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire logic [ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic rx_pin,
   input wire logic raw_framing_error,
   input wire logic raw_rx_full,
   output logic rx_data_q,
   output logic framing_error_flag_q,
   output logic rx_full_flag_q,
   output logic irq_q
);
   logic line_s;
   logic rx_prev_q;
   logic break_seen_flag_q;
   logic rx_edge_flag_q;
   logic rx_polarity_invert_q;
   logic long_break_detect_enable_q;
   logic nine_bit_q;
   logic [DW-1:0] bit_div_q;
   logic [7:0] irq_mask_q;
   logic [31:0] rdata_d;
   logic wr_ok;
   logic brk_found;
   logic edge_hit;
   logic [CNT_W-1:0] brk_bits;
   logic [7:0] status_byte;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   sbes_sync u_sync
   (
      .clock(clock),
      .reset(reset),
      .clock_enable(clock_enable),
      .pin(rx_pin),
      .level_q(line_s)
   );

   // Longer threshold while break enable is set; nine-bit frames add one more
   assign brk_bits = BRK_BITS_SHORT + (long_break_detect_enable_q ? BRK_BITS_ONE : '0)
      + (nine_bit_q ? BRK_BITS_ONE : '0);

   sbes_break #(.DW(DW)) u_break
   (
      .clock(clock),
      .reset(reset),
      .clock_enable(clock_enable),
      .line(rx_data_q),
      .bit_div(bit_div_q),
      .bits_needed(brk_bits),
      .found_q(brk_found)
   );

   // Accepted bus write: the edge at which waitrequest is seen low
   assign wr_ok = write && !waitrequest && clock_enable;
   // Taken on the pin side so that flipping the polarity while idle is not an edge
   assign edge_hit = rx_polarity_invert_q ? (!rx_prev_q && line_s) : (rx_prev_q && !line_s);

   assign status_byte = {break_seen_flag_q, rx_edge_flag_q, 1'b0, rx_polarity_invert_q,
      2'b00, long_break_detect_enable_q, rx_data_q};

   // Polarity correction for everything the receiver sees
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         rx_data_q <= 1'b1;
         rx_prev_q <= 1'b1;
      end
      else if (clock_enable)
      begin
         rx_data_q <= line_s ^ rx_polarity_invert_q;
         rx_prev_q <= line_s;
      end
   end

   // Event flags: a set in the same cycle as a clear wins
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         break_seen_flag_q <= 1'b0;
         rx_edge_flag_q <= 1'b0;
      end
      else if (clock_enable)
      begin
         if (brk_found && long_break_detect_enable_q)
            break_seen_flag_q <= 1'b1;
         else if (wr_ok && hit(address, OFS_STATUS_TWO) && byteenable[0] && writedata[BIT_BREAK])
            break_seen_flag_q <= 1'b0;
         if (edge_hit)
            rx_edge_flag_q <= 1'b1;
         else if (wr_ok && hit(address, OFS_STATUS_TWO) && byteenable[0] && writedata[BIT_EDGE])
            rx_edge_flag_q <= 1'b0;
      end
   end

   // Control registers
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         rx_polarity_invert_q <= 1'b0;
         long_break_detect_enable_q <= 1'b0;
         nine_bit_q <= 1'b0;
         irq_mask_q <= MASK_RESET;
      end
      else if (wr_ok && byteenable[0])
      begin
         if (hit(address, OFS_STATUS_TWO))
         begin
            rx_polarity_invert_q <= writedata[BIT_INVERT];
            long_break_detect_enable_q <= writedata[BIT_LONG_BRK];
         end
         else if (hit(address, OFS_LINE_CFG))
            nine_bit_q <= writedata[BIT_NINE];
         else if (hit(address, OFS_IRQ_MASK))
            irq_mask_q <= writedata[7:0] & EVENT_BITS;
      end
   end

   // Divisor in one process, each byte on its own lane
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         bit_div_q <= DIV_INIT;
      else if (wr_ok && hit(address, OFS_BIT_DIV))
      begin
         if (byteenable[0])
            bit_div_q[7:0] <= writedata[7:0];
         if (byteenable[1])
            bit_div_q[DW-1:8] <= writedata[DW-1:8];
      end
   end

   always_comb
   begin
      rdata_d = '0;
      if (hit(address, OFS_STATUS_TWO))
         rdata_d[7:0] = status_byte;
      else if (hit(address, OFS_LINE_CFG))
         rdata_d[BIT_NINE] = nine_bit_q;
      else if (hit(address, OFS_BIT_DIV))
         rdata_d[DW-1:0] = bit_div_q;
      else if (hit(address, OFS_IRQ_MASK))
         rdata_d[7:0] = irq_mask_q;
   end

   // One wait cycle per access; unmapped offsets read zero, writes ignored
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         waitrequest <= 1'b1;
         readdata <= '0;
      end
      else if (clock_enable)
      begin
         if ((read || write) && waitrequest)
         begin
            waitrequest <= 1'b0;
            readdata <= read ? rdata_d : '0;
         end
         else
            waitrequest <= 1'b1;
      end
   end

   // Receiver gating and interrupt
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         framing_error_flag_q <= 1'b0;
         rx_full_flag_q <= 1'b0;
         irq_q <= 1'b0;
      end
      else if (clock_enable)
      begin
         framing_error_flag_q <= raw_framing_error && !long_break_detect_enable_q;
         rx_full_flag_q <= raw_rx_full && !long_break_detect_enable_q;
         irq_q <= |({break_seen_flag_q, rx_edge_flag_q, 6'h00} & irq_mask_q);
      end
   end

   break_set_a: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && brk_found && long_break_detect_enable_q) |=> break_seen_flag_q)
      else $error("break flag not set after detection");

   break_clear_a: assert property (@(posedge clock) disable iff (reset)
      (wr_ok && hit(address, OFS_STATUS_TWO) && byteenable[0] && writedata[BIT_BREAK]
      && !(brk_found && long_break_detect_enable_q)) |=> !break_seen_flag_q)
      else $error("break flag not cleared by write one");

   edge_fall_a: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && !rx_polarity_invert_q && rx_prev_q && !line_s) |=> rx_edge_flag_q)
      else $error("edge flag not set on falling pin edge");

   edge_rise_a: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && rx_polarity_invert_q && !rx_prev_q && line_s) |=> rx_edge_flag_q)
      else $error("edge flag not set on rising pin edge");

   edge_clear_a: assert property (@(posedge clock) disable iff (reset)
      (wr_ok && hit(address, OFS_STATUS_TWO) && byteenable[0] && writedata[BIT_EDGE] && !edge_hit)
      |=> !rx_edge_flag_q)
      else $error("edge flag not cleared by write one");

   rx_invert_a: assert property (@(posedge clock) disable iff (reset)
      clock_enable |=> (rx_data_q == ($past(line_s) ^ $past(rx_polarity_invert_q))))
      else $error("receive data polarity wrong");

   break_low_a: assert property (@(posedge clock) disable iff (reset)
      brk_found |-> !$past(rx_data_q))
      else $error("break reported on a non-low corrected line");

   gate_fe_a: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && long_break_detect_enable_q) |=> (!framing_error_flag_q && !rx_full_flag_q))
      else $error("error or full flag leaked during break enable");

   flag_hold_a: assert property (@(posedge clock) disable iff (reset)
      (break_seen_flag_q && !(wr_ok && hit(address, OFS_STATUS_TWO) && byteenable[0]
      && writedata[BIT_BREAK])) |=> break_seen_flag_q)
      else $error("break flag dropped without a clear");

   irq_level_a: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && $past(clock_enable) && $stable(irq_mask_q) && rx_edge_flag_q && irq_mask_q[BIT_EDGE])
      |=> irq_q)
      else $error("interrupt missing for unmasked flag");

   edge_quiet_a: assert property (@(posedge clock) disable iff (reset)
      $rose(rx_edge_flag_q) |-> $past(edge_hit))
      else $error("edge flag set without an active edge");

   break_rise_a: assert property (@(posedge clock) disable iff (reset)
      $rose(break_seen_flag_q) |-> ($past(brk_found) && $past(long_break_detect_enable_q)))
      else $error("break flag set without an enabled detection");

   break_gate_a: assert property (@(posedge clock) disable iff (reset)
      (!long_break_detect_enable_q && !break_seen_flag_q) |=> !break_seen_flag_q)
      else $error("break flag set while detection disabled");

   edge_hold_a: assert property (@(posedge clock) disable iff (reset)
      (rx_edge_flag_q && !(wr_ok && hit(address, OFS_STATUS_TWO) && byteenable[0]
      && writedata[BIT_EDGE])) |=> rx_edge_flag_q)
      else $error("edge flag dropped without a clear");

   flag_pass_a: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && !long_break_detect_enable_q) |=> ((framing_error_flag_q == $past(raw_framing_error))
      && (rx_full_flag_q == $past(raw_rx_full))))
      else $error("error or full flag not passed with break enable clear");

   found_once_a: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && brk_found) |=> !brk_found)
      else $error("break report longer than one cycle");

   wait_answer_a: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && (read || write) && waitrequest) |=> !waitrequest)
      else $error("bus request not answered next cycle");

   wait_pulse_a: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && !waitrequest) |=> waitrequest)
      else $error("waitrequest low for more than one cycle");

   status_read_a: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && read && waitrequest && hit(address, OFS_STATUS_TWO))
      |=> (readdata[7:0] == $past(status_byte)))
      else $error("status read data wrong");

   unmapped_read_a: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && read && waitrequest && !hit(address, OFS_STATUS_TWO) && !hit(address, OFS_LINE_CFG)
      && !hit(address, OFS_BIT_DIV) && !hit(address, OFS_IRQ_MASK)) |=> (readdata == 32'h0))
      else $error("unmapped offset read not zero");

   irq_quiet_a: assert property (@(posedge clock) disable iff (reset)
      (clock_enable && !(|({break_seen_flag_q, rx_edge_flag_q, 6'h00} & irq_mask_q))) |=> !irq_q)
      else $error("interrupt high with no unmasked flag");
endmodule

/* File: hdl/sbes_pkg.sv */
/*
   Package for the serial break and edge status block: register word offsets,
   field positions, reset values and break length figures.
   Assumes a 32-bit Avalon-MM register bus with byte addressing.
*/
package sbes_pkg;
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] OFS_STATUS_TWO = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_LINE_CFG = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_BIT_DIV = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'hc;

   localparam int BIT_BREAK = 7;
   localparam int BIT_EDGE = 6;
   localparam int BIT_INVERT = 4;
   localparam int BIT_LONG_BRK = 1;
   localparam int BIT_LINE = 0;
   localparam int BIT_NINE = 0;

   localparam logic [7:0] EVENT_BITS = 8'hc0;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam int DIV_W = 16;
   localparam logic [DIV_W-1:0] DIV_RESET = 16'h01b2;

   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] BRK_BITS_SHORT = 4'ha;
   localparam logic [CNT_W-1:0] BRK_BITS_ONE = 4'h1;
endpackage

/* File: hdl/sbes_sync.sv */
/*
   Two-stage synchroniser for the receive pin.
   Assumes the pin is asynchronous to clock; only the second stage is read.
*/
`timescale 1ns/1ns
module sbes_sync
(
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire logic pin,
   output logic level_q
);
   logic meta_q;

   // Idle line is high, so both stages reset high to avoid a false edge
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         meta_q <= 1'b1;
         level_q <= 1'b1;
      end
      else if (clock_enable)
      begin
         meta_q <= pin;
         level_q <= meta_q;
      end
   end
endmodule

/* File: hdl/sbes_break.sv */
/*
   Break length detector: measures how long the receive line stays low
   in whole bit times and pulses once when the threshold is reached.
   Assumes a line already synchronised and polarity corrected.
*/
`timescale 1ns/1ns
module sbes_break
   import sbes_pkg::*;
#(
   parameter int DW = DIV_W
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic clock_enable,
   input wire logic line,
   input wire logic [DW-1:0] bit_div,
   input wire logic [CNT_W-1:0] bits_needed,
   output logic found_q
);
   logic [DW-1:0] tick_q;
   logic [CNT_W-1:0] bits_q;
   logic done_q;

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         tick_q <= '0;
         bits_q <= '0;
         done_q <= 1'b0;
         found_q <= 1'b0;
      end
      else if (clock_enable)
      begin
         found_q <= 1'b0;
         if (line)
         begin
            tick_q <= '0;
            bits_q <= '0;
            done_q <= 1'b0;
         end
         else if (!done_q)
         begin
            if (tick_q + 1'b1 >= bit_div)
            begin
               tick_q <= '0;
               bits_q <= bits_q + 1'b1;
               // One report per low stretch; a stuck line does not repeat it
               if (bits_q + 1'b1 >= bits_needed)
               begin
                  done_q <= 1'b1;
                  found_q <= 1'b1;
               end
            end
            else
            begin
               tick_q <= tick_q + 1'b1;
            end
         end
      end
   end
endmodule

/* File: sim/sbes_lin_tx.sv */
/*
   Serial transmitter model on the receive pin: idle high, drives low stretches.
   Assumes its task is called just after a rising clock edge.
*/
`timescale 1ns/1ns
module sbes_lin_tx
(
   input wire logic clock,
   output logic line_q
);
   initial line_q = 1'b1;
   // Level holds after return, so a low stretch may be lengthened by further calls
   task automatic level(input logic lvl, input int n);
      line_q <= lvl;
      repeat (n) @(posedge clock);
   endtask
endmodule

/* File: sim/tb_top.sv */
/*
   Self-checking bench for the break and edge status block.
   Assumes a 50 MHz clock, an Avalon-MM master here and the serial model on rx_pin.
*/
`timescale 1ns/1ns
module tb_top
   import sbes_pkg::*;
;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [ADDR_W-1:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic raw_fe = 1'b0;
   logic raw_full = 1'b0;
   logic ce = 1'b1;
   logic [31:0] readdata;
   logic [31:0] rd;
   logic waitrequest, rx_pin, rx_data_q, fe_q, full_q, irq_q;
   int n_fail = 0;
   int checked = 0;
   int cyc = 0;

   always #10 clock = ~clock;

   sbes_lin_tx tx_u (.clock(clock), .line_q(rx_pin));

   sbes_top dut_u (.clock(clock), .reset(reset), .clock_enable(ce), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(4'hf), .readdata(readdata),
      .waitrequest(waitrequest), .rx_pin(rx_pin), .raw_framing_error(raw_fe), .raw_rx_full(raw_full),
      .rx_data_q(rx_data_q), .framing_error_flag_q(fe_q), .rx_full_flag_q(full_q), .irq_q(irq_q));

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Leading edge keeps a new request from landing in the step that released the last one
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clock);
      address <= a;
      writedata <= d;
      write <= wr;
      read <= ~wr;
      do @(posedge clock); while (waitrequest !== 1'b0);
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask

   task automatic rdchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(what, rd, exp);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clock);
      @(negedge clock);
   endtask

   task automatic t_reset();
      rdchk("status", OFS_STATUS_TWO, 32'h01);
      rdchk("mask", OFS_IRQ_MASK, 32'h0);
      rdchk("divisor", OFS_BIT_DIV, 32'h01b2);
      rdchk("unmapped", 4'h2, 32'h0);
      chk("rx data idle", rx_data_q, 32'h1);
      $display("test reset done");
   endtask

   // A pin pulse while the enable is low must leave no trace
   task automatic t_freeze();
      ce <= 1'b0;
      tx_u.level(1'b0, 8);
      chk("frozen line", rx_data_q, 32'h1);
      tx_u.level(1'b1, 2);
      ce <= 1'b1;
      rdchk("frozen edge", OFS_STATUS_TWO, 32'h01);
      $display("test freeze done");
   endtask

   task automatic t_edge();
      bus(1'b1, OFS_IRQ_MASK, 32'h40);
      tx_u.level(1'b0, 6);
      rdchk("edge set", OFS_STATUS_TWO, 32'h40);
      settle(1);
      chk("irq high", irq_q, 32'h1);
      @(posedge clock);
      tx_u.level(1'b1, 6);
      tx_u.level(1'b0, 6);
      bus(1'b1, OFS_STATUS_TWO, 32'h0);
      rdchk("edge kept", OFS_STATUS_TWO, 32'h40);
      tx_u.level(1'b1, 6);
      bus(1'b1, OFS_STATUS_TWO, 32'h40);
      rdchk("edge clear", OFS_STATUS_TWO, 32'h01);
      settle(2);
      chk("irq low", irq_q, 32'h0);
      $display("test edge done");
   endtask

   task automatic t_invert();
      bus(1'b1, OFS_IRQ_MASK, 32'h0);
      bus(1'b1, OFS_STATUS_TWO, 32'h10);
      settle(4);
      chk("inverted idle", rx_data_q, 32'h0);
      chk("irq masked", irq_q, 32'h0);
      rdchk("inv no edge", OFS_STATUS_TWO, 32'h10);
      bus(1'b1, OFS_STATUS_TWO, 32'h50);
      tx_u.level(1'b0, 6);
      rdchk("inv fall", OFS_STATUS_TWO, 32'h11);
      chk("inverted low", rx_data_q, 32'h1);
      tx_u.level(1'b1, 6);
      rdchk("inv rise", OFS_STATUS_TWO, 32'h50);
      bus(1'b1, OFS_STATUS_TWO, 32'h40);
      $display("test invert done");
   endtask

   // Stretches of one bit under and one bit over each threshold give a margin for sync delay
   task automatic t_break();
      logic [31:0] e;
      int thr;
      bus(1'b1, OFS_BIT_DIV, 32'h4);
      raw_fe <= 1'b1;
      raw_full <= 1'b1;
      for (int m = 0; m < 4; m++)
      begin
         e = 32'(m & 1);
         thr = 10 + (m & 1) + (m >> 1);
         bus(1'b1, OFS_LINE_CFG, 32'(m >> 1));
         bus(1'b1, OFS_STATUS_TWO, 32'hc0 | (e << 1));
         settle(2);
         chk("fe gate", fe_q, e ^ 32'h1);
         chk("full gate", full_q, e ^ 32'h1);
         @(posedge clock);
         tx_u.level(1'b0, (thr - 1) * 4);
         rdchk("break short", OFS_STATUS_TWO, 32'h40 | (e << 1));
         tx_u.level(1'b0, 8);
         rdchk("break long", OFS_STATUS_TWO, 32'h40 | (e << 7) | (e << 1));
         tx_u.level(1'b1, 8);
         bus(1'b1, OFS_STATUS_TWO, 32'h80 | (e << 1));
         rdchk("break clear", OFS_STATUS_TWO, 32'h41 | (e << 1));
      end
      $display("test break done");
   endtask

   task automatic end_sim();
      $display("checks %0d failures %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge clock)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         $display("FAIL timeout expected done seen hang");
         end_sim();
      end
   end

   initial
   begin
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      t_reset();
      t_freeze();
      t_edge();
      t_invert();
      t_break();
      end_sim();
   end
endmodule
